// ---- core/eqo_top.sv ----
// Purpose: quadrature encoder pulse output with absolute position transfer
// Assumes: position input and servo state are on ref_clk; request pin is asynchronous
// Notes:   configuration objects are written by index over a simple write port
//
// How it works
// - pulses out per motor revolution follow the pulses-per-revolution object.
// - the phase-lead object selects whether A leads B or B leads A.
// - quadrature edges never come faster than 6.5 million per second.
// - A, B and Z are driven each as a true and complement pair.
// - the output pulse count is further divided by the demultiplication object.
// - absolute data goes out as quadrature pulses on A and B at 500 k edges per second.
// - multi-turn count is sent first, single-turn position second.
// - a request is only honoured while the servo is off.
// - after the request the block waits 100 ms before sending.
// - multi-turn data is sent within 200 ms and single-turn starts 200 ms later.
// - single-turn data is sent within 1200 ms, scaled by the output ratio.
// - normal output resumes after 1200 ms of single-turn sending, once the request is released.
`timescale 1ns/1ps
`include "eqo_params.svh"

module eqo_top
    import eqo_pkg::*;
#(
    parameter int unsigned WAIT_CYC   = `EQO_WAIT_MS * `EQO_CYC_PER_MS,
    parameter int unsigned MULTI_CYC  = `EQO_MULTI_MS * `EQO_CYC_PER_MS,
    parameter int unsigned SINGLE_CYC = `EQO_SINGLE_MS * `EQO_CYC_PER_MS
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire eqo_cfg_wr_t cfg_wr,
    input  wire logic [15:0] cfg_rd_idx,
    output logic      [31:0] cfg_rd_data,
    input  wire logic [31:0] enc_position,
    input  wire logic [31:0] multi_turn,
    input  wire logic        servo_on,
    input  wire logic        absolute_data_request,
    output eqo_pins_t        enc_pins,
    output logic             abs_busy
);

    localparam logic [31:0] ABS_DIV  = 32'(`EQO_ABS_EDGE_DIV);
    localparam logic [31:0] MIN_DIV  = 32'(`EQO_MIN_EDGE_DIV);
    localparam logic [31:0] CPR      = `EQO_ENC_COUNTS_PER_REV;

    // configuration objects
    logic [31:0] ppr_r;
    logic [15:0] lead_r;
    logic [31:0] demult_r;
    logic [15:0] ctrl_in2_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ppr_r      <= `EQO_PPR_RESET;
            lead_r     <= `EQO_LEAD_RESET;
            demult_r   <= `EQO_DEMULT_RESET;
            ctrl_in2_r <= 16'h0000;
        end else if (cfg_wr.wr) begin
            if (cfg_wr.idx == `EQO_IDX_PULSES_PER_REV) begin
                ppr_r <= cfg_wr.data;
            end else if (cfg_wr.idx == `EQO_IDX_PHASE_LEAD) begin
                lead_r <= cfg_wr.data[15:0];
            end else if (cfg_wr.idx == `EQO_IDX_DEMULT) begin
                demult_r <= (cfg_wr.data == 32'h0) ? 32'h1 : cfg_wr.data;
            end else if (cfg_wr.idx == `EQO_IDX_CTRL_IN2) begin
                ctrl_in2_r <= cfg_wr.data[15:0];
            end
        end
    end

    // read back; unknown indices read zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_rd_data <= 32'h0;
        end else if (cfg_rd_idx == `EQO_IDX_PULSES_PER_REV) begin
            cfg_rd_data <= ppr_r;
        end else if (cfg_rd_idx == `EQO_IDX_PHASE_LEAD) begin
            cfg_rd_data <= {16'h0, lead_r};
        end else if (cfg_rd_idx == `EQO_IDX_DEMULT) begin
            cfg_rd_data <= demult_r;
        end else if (cfg_rd_idx == `EQO_IDX_CTRL_IN2) begin
            cfg_rd_data <= {16'h0, ctrl_in2_r};
        end else begin
            cfg_rd_data <= 32'h0;
        end
    end

    // request pin synchroniser; first stage read only by second
    logic req_s1_r;
    logic req_s2_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
        end else begin
            req_s1_r <= absolute_data_request;
            req_s2_r <= req_s1_r;
        end
    end

    // effective output pulses per rev after demultiplication
    logic [31:0] eff_ppr;
    assign eff_ppr = (ppr_r / demult_r == 32'h0) ? 32'h1 : ppr_r / demult_r;

    // scale encoder counts into output quadrature edges (4 per pulse)
    function automatic logic [31:0] eqo_scale(input logic [31:0] cnt, input logic [31:0] ppr);
        logic [63:0] prod;
        prod = 64'(cnt) * 64'(ppr) * 64'd4;
        return 32'(prod / 64'(CPR));
    endfunction : eqo_scale

    // target edge count inside the revolution
    logic [31:0] single_pos;
    logic [31:0] tgt_edges;
    assign single_pos = enc_position % CPR;
    assign tgt_edges  = eqo_scale(single_pos, eff_ppr);

    // sequencer
    eqo_state_t  state_r;
    logic [31:0] tmr_r;
    logic [31:0] send_left_r;
    logic        req_seen_r;
    logic        rq_rise;
    assign rq_rise = (req_s2_r || ctrl_in2_r[`EQO_CTRL_IN2_ABS_BIT]) && !req_seen_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            req_seen_r <= 1'b0;
        end else begin
            req_seen_r <= req_s2_r || ctrl_in2_r[`EQO_CTRL_IN2_ABS_BIT];
        end
    end

    logic [31:0] div_r;
    logic        edge_tick;
    assign edge_tick = (div_r == 32'h0);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r     <= EQO_ST_NORMAL;
            tmr_r       <= 32'h0;
            send_left_r <= 32'h0;
        end else begin
            case (state_r)
                EQO_ST_NORMAL: begin
                    if (rq_rise && !servo_on) begin
                        state_r <= EQO_ST_WAIT;
                        tmr_r   <= 32'h0;
                    end
                end
                EQO_ST_WAIT: begin
                    tmr_r <= tmr_r + 32'h1;
                    if (tmr_r == WAIT_CYC - 1) begin
                        state_r     <= EQO_ST_MULTI;
                        tmr_r       <= 32'h0;
                        send_left_r <= {multi_turn[29:0], 2'b00};
                    end
                end
                EQO_ST_MULTI: begin
                    tmr_r <= tmr_r + 32'h1;
                    if (edge_tick && send_left_r != 32'h0) begin
                        send_left_r <= send_left_r - 32'h1;
                    end
                    if (tmr_r == MULTI_CYC - 1) begin
                        state_r     <= EQO_ST_SINGLE;
                        tmr_r       <= 32'h0;
                        send_left_r <= tgt_edges;
                    end
                end
                EQO_ST_SINGLE: begin
                    tmr_r <= tmr_r + 32'h1;
                    if (edge_tick && send_left_r != 32'h0) begin
                        send_left_r <= send_left_r - 32'h1;
                    end
                    if (tmr_r == SINGLE_CYC - 1) begin
                        state_r <= EQO_ST_HOLD;
                    end
                end
                EQO_ST_HOLD: begin
                    // waits for request release so one request gives one transfer
                    if (!req_seen_r) begin
                        state_r <= EQO_ST_NORMAL;
                    end
                end
                default: state_r <= EQO_ST_NORMAL;
            endcase
        end
    end

    // edge pacing divider: fixed rate when sending, limited rate when tracking
    logic [31:0] div_load;
    assign div_load = (state_r == EQO_ST_MULTI || state_r == EQO_ST_SINGLE) ? ABS_DIV - 32'h1
                                                                          : MIN_DIV - 32'h1;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_r <= 32'h0;
        end else if (edge_tick) begin
            div_r <= div_load;
        end else begin
            div_r <= div_r - 32'h1;
        end
    end

    // normal tracking: follow the divided position one edge per tick
    logic [31:0] out_edges_r;
    logic [1:0]  quad_r;
    logic        step_up;
    logic        step_dn;
    logic        sending;
    assign sending = (state_r == EQO_ST_MULTI || state_r == EQO_ST_SINGLE);
    // distance to target taken around the revolution, so the wrap at the
    // index moves one edge forward instead of unwinding a whole turn
    logic [31:0] trk_mod;
    logic [31:0] trk_diff;
    assign trk_mod  = eff_ppr << 2;
    assign trk_diff = (tgt_edges >= out_edges_r) ? tgt_edges - out_edges_r
                                                 : tgt_edges + trk_mod - out_edges_r;
    assign step_up = edge_tick && (sending ? (send_left_r != 32'h0)
                                           : (state_r == EQO_ST_NORMAL && trk_diff != 32'h0
                                              && trk_diff < (eff_ppr << 1)));
    assign step_dn = edge_tick && !sending && state_r == EQO_ST_NORMAL && trk_diff != 32'h0
                     && trk_diff >= (eff_ppr << 1);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            out_edges_r <= 32'h0;
            quad_r      <= 2'b00;
        end else begin
            if (step_up) begin
                quad_r <= quad_r + 2'b01;
                if (!sending) begin
                    out_edges_r <= (out_edges_r + 32'h1 >= (eff_ppr << 2)) ? 32'h0 : out_edges_r + 32'h1;
                end
            end else if (step_dn) begin
                quad_r      <= quad_r - 2'b01;
                out_edges_r <= (out_edges_r == 32'h0) ? (eff_ppr << 2) - 32'h1 : out_edges_r - 32'h1;
            end
            if (state_r == EQO_ST_HOLD) begin
                out_edges_r <= tgt_edges; // resync after transfer
            end
        end
    end

    // gray-code phases; lead select swaps A and B
    logic ph_a;
    logic ph_b;
    // a moves first on an up count, so lead select 0 gives a leading b
    assign ph_a = quad_r[1] ^ quad_r[0];
    assign ph_b = quad_r[1];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enc_pins <= 6'b010101;
            abs_busy <= 1'b0;
        end else begin
            enc_pins.a   <= lead_r[0] ? ph_b : ph_a;
            enc_pins.a_n <= lead_r[0] ? !ph_b : !ph_a;
            enc_pins.b   <= lead_r[0] ? ph_a : ph_b;
            enc_pins.b_n <= lead_r[0] ? !ph_a : !ph_b;
            enc_pins.z   <= state_r == EQO_ST_NORMAL && out_edges_r == 32'h0;
            enc_pins.z_n <= !(state_r == EQO_ST_NORMAL && out_edges_r == 32'h0);
            abs_busy     <= state_r != EQO_ST_NORMAL;
        end
    end

    // cycles since the last quadrature step, saturating; only the checks read it
    logic [31:0] edge_gap_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            edge_gap_r <= 32'hffff_ffff;
        end else if (step_up || step_dn) begin
            edge_gap_r <= 32'h0;
        end else if (edge_gap_r != 32'hffff_ffff) begin
            edge_gap_r <= edge_gap_r + 32'h1;
        end
    end

    AST_PAIR_A: assert property (@(posedge ref_clk) disable iff (reset) enc_pins.a != enc_pins.a_n)
        else $error("phase a pair not complementary");
    AST_PAIR_B: assert property (@(posedge ref_clk) disable iff (reset) enc_pins.b != enc_pins.b_n)
        else $error("phase b pair not complementary");
    AST_PAIR_Z: assert property (@(posedge ref_clk) disable iff (reset) enc_pins.z != enc_pins.z_n)
        else $error("index pair not complementary");
    AST_TRACK_GAP: assert property (@(posedge ref_clk) disable iff (reset)
        (step_up || step_dn) |-> edge_gap_r >= MIN_DIV - 32'h1)
        else $error("quadrature steps closer than the rate limit");
    AST_ABS_RATE: assert property (@(posedge ref_clk) disable iff (reset)
        (sending && step_up) |-> edge_gap_r >= ABS_DIV - 32'h1)
        else $error("absolute data edges faster than the fixed rate");
    AST_NO_REQ_SERVO_ON: assert property (@(posedge ref_clk) disable iff (reset)
        (state_r == EQO_ST_NORMAL && servo_on) |=> state_r != EQO_ST_WAIT)
        else $error("request honoured while servo on");
    AST_MULTI_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
        (state_r == EQO_ST_WAIT) |=> state_r != EQO_ST_SINGLE)
        else $error("single turn sent before multi turn");
    AST_EDGE_LIMIT: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(quad_r) |=> !$changed(quad_r))
        else $error("edge rate limit exceeded");
endmodule : eqo_top

// ---- core/eqo_params.svh ----
// Purpose: constants for the encoder pulse output and absolute transfer block
// Assumes: 125 MHz ref_clk, 8 ns period
// Notes:   object indices are kept as register indices
`ifndef EQO_PARAMS_SVH
`define EQO_PARAMS_SVH

`define EQO_IDX_PULSES_PER_REV   16'h2422
`define EQO_IDX_PHASE_LEAD       16'h2423
`define EQO_IDX_DEMULT           16'h2442
`define EQO_IDX_CTRL_IN2         16'h2120
`define EQO_CTRL_IN2_ABS_BIT     0
`define EQO_CLK_HZ               125000000
`define EQO_MAX_EDGE_PPS_X10     65
`define EQO_MAX_EDGE_PPS_UNIT    100000
`define EQO_ABS_PPS_K            500
`define EQO_ABS_EDGE_DIV         ((`EQO_CLK_HZ + (`EQO_ABS_PPS_K * 1000) - 1) / (`EQO_ABS_PPS_K * 1000))
`define EQO_MIN_EDGE_DIV         ((`EQO_CLK_HZ + (`EQO_MAX_EDGE_PPS_X10 * `EQO_MAX_EDGE_PPS_UNIT) - 1) / (`EQO_MAX_EDGE_PPS_X10 * `EQO_MAX_EDGE_PPS_UNIT))
`define EQO_WAIT_MS              100
`define EQO_MULTI_MS             200
`define EQO_SINGLE_MS            1200
`define EQO_CYC_PER_MS           (`EQO_CLK_HZ / 1000)
`define EQO_PPR_RESET            32'h0000_2710
`define EQO_LEAD_RESET           16'h0000
`define EQO_DEMULT_RESET         32'h0000_0001
`define EQO_ENC_COUNTS_PER_REV   32'h0001_0000

`endif

// ---- core/eqo_pkg.sv ----
// Purpose: types for the encoder pulse output block
// Assumes: constants come from eqo_params.svh
// Notes:   none
package eqo_pkg;
    typedef struct packed {
        logic a;
        logic a_n;
        logic b;
        logic b_n;
        logic z;
        logic z_n;
    } eqo_pins_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] idx;
        logic [31:0] data;
    } eqo_cfg_wr_t;

    typedef enum logic [4:0] {
        EQO_ST_NORMAL = 5'b00001,
        EQO_ST_WAIT   = 5'b00010,
        EQO_ST_MULTI  = 5'b00100,
        EQO_ST_SINGLE = 5'b01000,
        EQO_ST_HOLD   = 5'b10000
    } eqo_state_t;
endpackage : eqo_pkg

// ---- sim/eqo_ctrl_model.sv ----
// Purpose: controller model that counts quadrature pulses
// Assumes: pins are registered on ref_clk
// Notes:   clr zeroes edges, net, z_cnt and pair_err and sets gap and min_gap high; min_gap tracks the closest two edges
`timescale 1ns/1ps

module eqo_ctrl_model
    import eqo_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      clr,
    input  wire eqo_pins_t pins,
    input  wire logic      want,
    output logic           req,
    output int             edges,
    output int             net,
    output int             z_cnt,
    output int             min_gap,
    output int             pair_err
);
    logic [1:0] p_r;
    logic       z_r;
    int         gap;
    wire  [1:0] p = {pins.b, pins.a ^ pins.b};

    // request only goes up once we are ready to count
    always_ff @(posedge ref_clk) begin
        req <= want;
    end

    // decode quadrature, a leading b counts up
    always_ff @(posedge ref_clk) begin
        p_r <= p;
        z_r <= pins.z;
        if (clr) begin
            edges    <= 0;
            net      <= 0;
            z_cnt    <= 0;
            pair_err <= 0;
            gap      <= 1000000;
            min_gap  <= 1000000;
        end else begin
            gap <= (p != p_r) ? 0 : gap + 1;
            if (p != p_r) begin
                edges <= edges + 1;
                net   <= net + ((p - p_r == 2'd1) ? 1 : -1);
                if (gap + 1 < min_gap) min_gap <= gap + 1;
            end
            if (pins.z && !z_r) z_cnt <= z_cnt + 1;
            // a pair that is not complementary would be misread by a line receiver
            if ({pins.a_n, pins.b_n, pins.z_n} !== ~{pins.a, pins.b, pins.z}) pair_err <= pair_err + 1;
        end
    end
endmodule : eqo_ctrl_model

// ---- sim/tb_encoder_pulse_output_abs_transfer.sv ----
// Purpose: bench for encoder pulse output and absolute transfer
// Assumes: transfer phases shortened through parameters
// Notes:   pulse counts come from the controller model
`timescale 1ns/1ps
`include "eqo_params.svh"

module tb_encoder_pulse_output_abs_transfer
    import eqo_pkg::*;
;
    localparam int W = 1000;
    localparam int M = 4000;
    localparam int S = 8000;
    typedef struct {logic [15:0] idx; logic [31:0] wd; logic [31:0] rd;} eqo_row_t;
    logic        ref_clk, reset, servo_on, want, clr, req, abs_busy;
    eqo_cfg_wr_t cfg_wr;
    logic [15:0] cfg_rd_idx;
    logic [31:0] cfg_rd_data, enc_position, multi_turn;
    eqo_pins_t   enc_pins;
    int          edges, net, z_cnt, min_gap, pair_err, n_mismatch, n_compared, k;
    eqo_row_t    rows [6] = '{
        '{16'h2422, 32'h10, 32'h10},
        '{16'h2423, 32'h1, 32'h1},
        '{16'h2423, 32'h0, 32'h0},
        '{16'h2442, 32'h0, 32'h1},
        '{16'h2442, 32'h2, 32'h2},
        '{16'h1234, 32'h5, 32'h0}};

    eqo_top #(.WAIT_CYC(W), .MULTI_CYC(M), .SINGLE_CYC(S)) eqo_top_inst (
        .ref_clk(ref_clk), .reset(reset), .cfg_wr(cfg_wr), .cfg_rd_idx(cfg_rd_idx),
        .cfg_rd_data(cfg_rd_data), .enc_position(enc_position), .multi_turn(multi_turn),
        .servo_on(servo_on), .absolute_data_request(req), .enc_pins(enc_pins), .abs_busy(abs_busy));
    eqo_ctrl_model eqo_ctrl_model_inst (
        .ref_clk(ref_clk), .clr(clr), .pins(enc_pins), .want(want), .req(req), .edges(edges),
        .net(net), .z_cnt(z_cnt), .min_gap(min_gap), .pair_err(pair_err));

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // settle on the falling edge so sampling never races the launch edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        @(posedge ref_clk) cfg_wr <= '{1'b1, idx, d};
        @(posedge ref_clk) cfg_wr.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        @(posedge ref_clk) cfg_rd_idx <= idx;
        cyc(1);
        chk("read data", exp, cfg_rd_data);
    endtask : rd

    // clear the counters, then turn the shaft one full revolution
    task automatic spin;
        @(posedge ref_clk) clr <= 1'b1;
        @(posedge ref_clk) clr <= 1'b0;
        repeat (4096) @(posedge ref_clk) enc_position <= enc_position + 32'h10;
        cyc(300);
    endtask : spin

    task automatic wait_busy(input logic v, input int lim);
        cyc(0);
        while (abs_busy !== v && lim > 0) begin
            cyc(1);
            lim--;
        end
        if (abs_busy !== v) begin
            n_mismatch++;
            $display("unexpected busy wait expected %0h seen %0h", v, abs_busy);
            final_report();
        end
    endtask : wait_busy

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        {reset, clr, cfg_wr, cfg_rd_idx, enc_position, multi_turn, servo_on, want} = '1;
        cfg_wr = '0;
        {enc_position, multi_turn, cfg_rd_idx, servo_on, want} = '0;
        cyc(8);
        chk("idle pins", 6'h15, enc_pins);
        chk("idle busy", 1'b0, abs_busy);
        @(posedge ref_clk) reset <= 1'b0;
        rd(16'h2422, `EQO_PPR_RESET);
        rd(16'h2423, `EQO_LEAD_RESET);
        rd(16'h2442, `EQO_DEMULT_RESET);
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            rd(rows[i].idx, rows[i].rd);
        end
        // lead forward, lead reversed, then halved by the ratio
        for (k = 0; k < 3; k++) begin
            wr(16'h2423, (k == 1) ? 32'h1 : 32'h0);
            wr(16'h2442, (k == 2) ? 32'h2 : 32'h1);
            spin();
            chk("edges per rev", 64 / ((k == 2) ? 2 : 1), edges);
            chk("direction", (k == 1) ? -64 : 64 / ((k == 2) ? 2 : 1), net);
            chk("index pulses", 1, z_cnt);
            chk("edge spacing", 1'b1, min_gap >= 20);
            chk("pair errors", 0, pair_err);
        end
        wr(16'h2442, 32'h1);
        // a request with the servo on must be ignored
        @(posedge ref_clk) servo_on <= 1'b1;
        @(posedge ref_clk) want <= 1'b1;
        cyc(W + 50);
        chk("busy servo on", 1'b0, abs_busy);
        @(posedge ref_clk) want <= 1'b0;
        servo_on <= 1'b0;
        multi_turn <= 32'h3;
        enc_position <= 32'h0004_4000;
        cyc(1000);
        @(posedge ref_clk) clr <= 1'b1;
        @(posedge ref_clk) clr <= 1'b0;
        want <= 1'b1;
        cyc(W);
        chk("edges in wait", 0, edges);
        chk("busy in wait", 1'b1, abs_busy);
        cyc(M - 100);
        chk("multi edges", 12, edges);
        cyc(S);
        chk("single edges", 28, edges);
        chk("abs spacing", 250, min_gap);
        chk("busy held", 1'b1, abs_busy);
        @(posedge ref_clk) want <= 1'b0;
        wait_busy(1'b0, 400);
        // request through the control word, then reset during the wait before sending
        wr(16'h2120, 32'h1);
        wait_busy(1'b1, 20);
        @(posedge ref_clk) reset <= 1'b1;
        cyc(2);
        chk("busy in reset", 1'b0, abs_busy);
        chk("pins in reset", 6'h15, enc_pins);
        @(posedge ref_clk) reset <= 1'b0;
        cyc(2);
        chk("busy after reset", 1'b0, abs_busy);
        final_report();
    end
endmodule : tb_encoder_pulse_output_abs_transfer
